/* src/uctl_top.sv */
`timescale 1ns/1ps
// Summary of operation
// RQ1: In trimmer mode, scan four trimmers and the volume pot through the converter.
// RQ2: A changed trimmer position updates mapped parameter values immediately.
// RQ3: Nineteen parameters can each be assigned to one of four trimmers.
// RQ4: Each trimmer parameter is a four-bit step index, sixteen values.
// RQ5: One trimmer may drive many parameters at once.
// RQ6: Volume may be fixed by a software register instead.
// RQ7: Analog and digital volume control never both active.
// RQ8: Digital volume takes momentary or rocker switch; rocker may select memory.
// RQ9: Pot position maps to gain by linear or logarithmic law.
// RQ10: With auto telecoil, closed second select switch jumps to fourth memory.
// RQ11: After debounced open, return to memory active before the jump.
// RQ12: A close-to-open transition starts a programmable-length debounce window.
// RQ13: Leave fourth memory only when every sample over the window read open. Code also leaves at once when autotcoil_en is cleared.
// RQ14: A closed sample in the window keeps fourth memory and restarts counting.
// RQ15: Jump works at startup and in operation; first switch ignored meanwhile.
// RQ16: Rocker memory mode: up goes to higher memory, down to lower.
`include "uctl_consts.svh"

module uctl_top
   import uctl_pkg::*;
#(
   parameter int NUM_TRIM = `UCTL_NUM_TRIM,
   parameter int NUM_PARAM = `UCTL_NUM_PARAM
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic first_memory_select_input,
   input wire logic second_memory_select_input,
   input wire logic vol_up_switch,
   input wire logic vol_down_switch,
   output logic [2:0] adc_sel,
   output logic adc_start,
   input wire logic adc_valid,
   input wire logic [7:0] adc_data,
   output logic [75:0] param_steps,
   output logic param_update,
   output logic [7:0] volume_gain,
   output logic [1:0] active_memory,
   output logic telecoil_active
);

   // Elaboration check on sizes the logic is built for
   if (NUM_TRIM != 4 || NUM_PARAM != 19) begin : g_bad_size
      $error("uctl_top supports four trimmers and nineteen parameters only");
   end

   uctl_state_t s;
   uctl_state_t next_s;

   // Log taper: exponent of leading one, then five mantissa bits
   function automatic logic [7:0] log_gain(input logic [7:0] p);
      logic [2:0] m;
      logic [7:0] sh;
      m = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (p[i]) begin
            m = 3'(i);
         end
      end
      sh = p << (3'h7 - m);
      if (p == 8'h00) begin
         log_gain = 8'h00;
      end else begin
         log_gain = {m, sh[6:2]};
      end
   endfunction

   logic [3:0] closed;
   logic [3:0] press;
   logic ready;
   logic apb_wr;
   logic [1:0] mem_top;
   logic [3:0] step;
   logic [7:0] pot_gain;

   always_comb begin
      next_s = s;
      next_s.param_update = 1'b0;
      next_s.adc.start = 1'b0;
      // Error flag only stands in the access cycle, alongside ready
      next_s.pslverr = 1'b0;
      apb_wr = psel && penable && s.pready && pwrite;

      // APB: answer prepared in setup cycle, one access cycle
      next_s.pready = psel && !penable && !s.pready;
      if (psel && !penable) begin
         next_s.prdata = 32'h0000_0000;
         if (paddr == `UCTL_CTRL_OFS) begin
            next_s.prdata = {23'h000000, s.ctrl};
         end else if (paddr == `UCTL_SVOL_OFS) begin
            next_s.prdata = {24'h000000, s.static_vol};
         end else if (paddr == `UCTL_DEB_OFS) begin
            next_s.prdata = {16'h0000, s.debounce};
         end else if (paddr == `UCTL_MAP0_OFS) begin
            next_s.prdata = s.map[7:0];
         end else if (paddr == `UCTL_MAP1_OFS) begin
            next_s.prdata = s.map[15:8];
         end else if (paddr == `UCTL_MAP2_OFS) begin
            next_s.prdata = {20'h00000, s.map[18:16]};
         end else if (paddr == `UCTL_STAT_OFS) begin
            next_s.prdata = {21'h000000, s.volume, s.in_induction_pickup_input, s.mem};
         end else if (paddr == `UCTL_TRIM_OFS) begin
            next_s.prdata = {8'h00, s.pot, s.trim_step};
         end else begin
            next_s.pslverr = 1'b1;
         end
      end
      if (apb_wr) begin
         if (paddr == `UCTL_CTRL_OFS) begin
            next_s.ctrl = pwdata[8:0];
         end else if (paddr == `UCTL_SVOL_OFS) begin
            next_s.static_vol = pwdata[7:0];
         end else if (paddr == `UCTL_DEB_OFS) begin
            next_s.debounce = pwdata[15:0];
         end else if (paddr == `UCTL_MAP0_OFS) begin
            next_s.map[7:0] = pwdata;
         end else if (paddr == `UCTL_MAP1_OFS) begin
            next_s.map[15:8] = pwdata;
         end else if (paddr == `UCTL_MAP2_OFS) begin
            next_s.map[18:16] = pwdata[11:0];
         end
      end

      // Three-stage synchronisers; level accepted when stages two and three agree
      next_s.sync1 = {vol_down_switch, vol_up_switch, second_memory_select_input, first_memory_select_input};
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;
      if (s.sync2 == s.sync3) begin
         next_s.filt = s.sync3;
      end
      if (s.settle != `UCTL_SETTLE_DONE) begin
         next_s.settle = s.settle + 2'h1;
      end
      ready = (s.settle == `UCTL_SETTLE_DONE);
      closed = (s.filt ^ {4{s.ctrl.switch_active_low}}) & {4{ready}};
      // Press is an open to closed event on the filtered level
      press = ((next_s.filt ^ {4{s.ctrl.switch_active_low}}) & {4{ready}}) & ~closed;

      // RQ1 converter scan
      // Round robin over four trimmers and the pot
      if (s.ctrl.trim_en || s.ctrl.vol_mode == UCTL_VOL_ANALOG) begin
         if (!s.adc.busy) begin
            next_s.adc.start = 1'b1;
            next_s.adc.busy = 1'b1;
         end else if (adc_valid) begin
            next_s.adc.busy = 1'b0;
            if (s.adc.sel == `UCTL_POT_CHAN) begin
               next_s.pot = adc_data;
               next_s.adc.sel = 3'h0;
            end else begin
               next_s.trim_step[s.adc.sel[1:0]] = adc_data[7:4];
               next_s.adc.sel = s.adc.sel + 3'h1;
            end
         end
      end else begin
         next_s.adc.busy = 1'b0;
         next_s.adc.sel = 3'h0;
      end

      // RQ3 parameter map
      // Each map nibble: 0 unassigned, 1..4 trimmer number
      for (int p = 0; p < 19; p++) begin
         // RQ4 step index
         step = 4'h0;
         for (int t = 0; t < 4; t++) begin
            // RQ5 shared trimmer
            if (s.map[p] == 4'(t + 1)) begin
               step = next_s.trim_step[t];
            end
         end
         // RQ2 immediate update
         if (s.ctrl.trim_en && step != s.params[p]) begin
            next_s.params[p] = step;
            next_s.param_update = 1'b1;
         end
      end

      // RQ9 taper select
      pot_gain = s.ctrl.log_law ? log_gain(s.pot) : s.pot;
      // RQ7 single volume source
      case (s.ctrl.vol_mode)
         UCTL_VOL_ANALOG: begin
            next_s.volume = pot_gain;
         end
         UCTL_VOL_MOMENTARY, UCTL_VOL_ROCKER: begin
            // RQ8 digital volume
            if (s.ctrl.vol_mode == UCTL_VOL_ROCKER && s.ctrl.rocker_mem) begin
               next_s.volume = s.static_vol;
            end else if (press[2] && s.volume != 8'hFF) begin
               next_s.volume = s.volume + 8'h01;
            end else if (press[3] && s.volume != 8'h00) begin
               next_s.volume = s.volume - 8'h01;
            end
         end
         default: begin
            // RQ6 static volume
            next_s.volume = s.static_vol;
         end
      endcase

      // Highest memory reachable by stepping; fourth reserved for telecoil when autotcoil_en is set
      mem_top = s.ctrl.max_mem;
      if (s.ctrl.autotcoil_en && mem_top == `UCTL_MEM_D) begin
         mem_top = 2'h2;
      end

      if (s.ctrl.autotcoil_en && closed[1]) begin
         // RQ10 telecoil jump
         // RQ15 also at startup, first switch ignored
         if (!s.in_induction_pickup_input) begin
            next_s.saved_mem = s.mem;
            next_s.in_induction_pickup_input = 1'b1;
         end
         next_s.mem = `UCTL_MEM_D;
         // RQ14 restart count
         next_s.dcount = 16'h0000;
      end else if (s.in_induction_pickup_input) begin
         // RQ12 debounce window
         // RQ13 all samples open
         if (s.dcount >= s.debounce || !s.ctrl.autotcoil_en) begin
            // RQ11 restore memory
            next_s.mem = s.saved_mem;
            next_s.in_induction_pickup_input = 1'b0;
            next_s.dcount = 16'h0000;
         end else begin
            next_s.dcount = s.dcount + 16'h0001;
         end
      end else if (s.ctrl.vol_mode == UCTL_VOL_ROCKER && s.ctrl.rocker_mem) begin
         // RQ16 rocker memory step
         if (press[2]) begin
            next_s.mem = (s.mem >= mem_top) ? 2'h0 : s.mem + 2'h1;
         end else if (press[3]) begin
            next_s.mem = (s.mem == 2'h0) ? mem_top : s.mem - 2'h1;
         end
      end else if (press[0]) begin
         next_s.mem = (s.mem >= mem_top) ? 2'h0 : s.mem + 2'h1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.ctrl <= `UCTL_CTRL_RST;
         s.static_vol <= `UCTL_SVOL_RST;
         s.debounce <= `UCTL_DEB_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign adc_sel = s.adc.sel;
   assign adc_start = s.adc.start;
   assign param_steps = s.params;
   assign param_update = s.param_update;
   assign volume_gain = s.volume;
   assign active_memory = s.mem;
   assign telecoil_active = s.in_induction_pickup_input;

endmodule

/* common/uctl_consts.svh */
`ifndef UCTL_CONSTS_SVH
`define UCTL_CONSTS_SVH
// Register byte offsets
`define UCTL_CTRL_OFS 12'h000
`define UCTL_SVOL_OFS 12'h004
`define UCTL_DEB_OFS 12'h008
`define UCTL_MAP0_OFS 12'h00C
`define UCTL_MAP1_OFS 12'h010
`define UCTL_MAP2_OFS 12'h014
`define UCTL_STAT_OFS 12'h020
`define UCTL_TRIM_OFS 12'h024
// Reset values
`define UCTL_CTRL_RST 9'h000
`define UCTL_SVOL_RST 8'h80
`define UCTL_DEB_RST 16'h0FA0
// Sizes and codes
`define UCTL_NUM_TRIM 4
`define UCTL_NUM_PARAM 19
`define UCTL_POT_CHAN 3'h4
`define UCTL_MEM_D 2'h3
`define UCTL_SETTLE_DONE 2'h3
`endif

/* common/uctl_pkg.sv */
package uctl_pkg;
   // Volume source, one encoding so only one external control is live
   typedef enum logic [1:0] {
      UCTL_VOL_STATIC,
      UCTL_VOL_ANALOG,
      UCTL_VOL_MOMENTARY,
      UCTL_VOL_ROCKER
   } uctl_vol_mode_t;

   // Software control word
   typedef struct packed {
      logic [1:0] max_mem;
      logic switch_active_low;
      logic autotcoil_en;
      logic rocker_mem;
      logic log_law;
      uctl_vol_mode_t vol_mode;
      logic trim_en;
   } uctl_ctrl_t;

   // Converter request and busy flag
   typedef struct packed {
      logic [2:0] sel;
      logic start;
      logic busy;
   } uctl_adc_t;

   // Whole block state
   typedef struct packed {
      uctl_ctrl_t ctrl;
      logic [7:0] static_vol;
      logic [15:0] debounce;
      logic [18:0][3:0] map;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] sync3;
      logic [3:0] filt;
      logic [1:0] settle;
      uctl_adc_t adc;
      logic [3:0][3:0] trim_step;
      logic [7:0] pot;
      logic [18:0][3:0] params;
      logic param_update;
      logic [7:0] volume;
      logic [1:0] mem;
      logic [1:0] saved_mem;
      logic in_induction_pickup_input;
      logic [15:0] dcount;
   } uctl_state_t;
endpackage

/* testbench/uctl_assertions.sv */
`timescale 1ns/1ps
`include "uctl_consts.svh"
module uctl_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] adc_sel,
   input wire logic adc_start,
   input wire logic param_update,
   input wire logic [1:0] active_memory,
   input wire logic telecoil_active,
   input wire logic second_memory_select_input
);
   logic [15:0] deb;
   logic [15:0] open_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Programmed debounce length and length of the raw open run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deb <= `UCTL_DEB_RST;
         open_cnt <= 16'h0000;
      end else begin
         if (psel && penable && pready && pwrite && paddr == `UCTL_DEB_OFS) deb <= pwdata[15:0];
         open_cnt <= second_memory_select_input ? 16'h0000 : open_cnt + {15'h0000, open_cnt != 16'hFFFF};
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_jump_held;
      telecoil_active ##1 telecoil_active;
   endsequence
   AST_PREADY_ONE: assert property (s_setup |=> pready)
      else $error("no answer in access cycle");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_SLVERR_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_SEL_RANGE: assert property (adc_start |-> adc_sel <= 3'h4)
      else $error("channel out of range");
   AST_SEL_STABLE: assert property (adc_start |=> $stable(adc_sel) && !adc_start)
      else $error("channel moved during conversion");
   AST_UPDATE_PULSE: assert property (param_update |=> !param_update)
      else $error("update pulse too long");
   AST_INDUCTION_PICKUP_INPUT_MEM: assert property (telecoil_active |-> active_memory == 2'h3)
      else $error("jump not in fourth memory");
   AST_INDUCTION_PICKUP_INPUT_HOLD: assert property (s_jump_held |-> $stable(active_memory))
      else $error("memory moved during jump");
   AST_INDUCTION_PICKUP_INPUT_DEB: assert property ($fell(telecoil_active) |-> open_cnt > deb)
      else $error("left jump before debounce ran out");
endmodule

/* testbench/uctl_adc_model.sv */
`timescale 1ns/1ps
module uctl_adc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] adc_sel,
   input wire logic adc_start,
   input wire logic [3:0] delay,
   input wire logic [4:0][7:0] pos,
   output logic adc_valid,
   output logic [7:0] adc_data
);
   logic [3:0] cnt;
   // Answers each start after a delay; data toggles outside the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         adc_valid <= 1'b0;
         adc_data <= 8'h00;
      end else begin
         adc_valid <= 1'b0;
         adc_data <= ~adc_data;
         if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               adc_valid <= 1'b1;
               adc_data <= pos[adc_sel];
            end
         end else if (adc_start) begin
            cnt <= delay + 4'h1;
         end
      end
   end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
`include "uctl_consts.svh"
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, adc_start, adc_valid, param_update, telecoil_active;
   logic first_memory_select_input = 1'b0, second_memory_select_input = 1'b0;
   logic vol_up_switch = 1'b0, vol_down_switch = 1'b0;
   logic [2:0] adc_sel;
   logic [7:0] adc_data, volume_gain;
   logic [75:0] param_steps;
   logic [1:0] active_memory;
   logic [3:0] delay = 4'h0;
   logic [4:0][7:0] pos = {8'h40, 8'h3C, 8'hE1, 8'h72, 8'hA5};
   int n_errors = 0, compares = 0;
   // Clock
   always #12.5 pclk = ~pclk;
   uctl_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .first_memory_select_input, .second_memory_select_input, .vol_up_switch, .vol_down_switch,
      .adc_sel, .adc_start, .adc_valid, .adc_data, .param_steps, .param_update, .volume_gain,
      .active_memory, .telecoil_active);
   uctl_adc_model partner (.pclk, .presetn, .adc_sel, .adc_start, .delay, .pos, .adc_valid, .adc_data);
   task automatic chk(input logic [75:0] got, input logic [75:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic summarize;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      hold(20000);
      n_errors++;
      summarize;
   end
   // Main sequence
   initial begin
      hold(3);
      presetn <= 1'b1;
      apb(1'b0, `UCTL_SVOL_OFS, 32'h0); chk(rd, 32'h80);
      apb(1'b0, `UCTL_DEB_OFS, 32'h0); chk(rd, 32'h0FA0);
      apb(1'b0, `UCTL_CTRL_OFS, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 12'h018, 32'h0); chk({err, rd}, {1'b1, 32'h0});
      apb(1'b1, `UCTL_DEB_OFS, 32'h5);
      apb(1'b1, `UCTL_MAP0_OFS, 32'h1111);
      apb(1'b1, `UCTL_MAP2_OFS, 32'h400);
      apb(1'b1, `UCTL_CTRL_OFS, 32'h23);
      repeat (300) if (volume_gain !== 8'h40) @(posedge pclk);
      chk(param_steps, {4'h3, 56'h0, 16'hAAAA});
      chk(volume_gain, 8'h40);
      apb(1'b0, `UCTL_TRIM_OFS, 32'h0); chk(rd, 32'h00403E7A);
      delay <= 4'h9;
      pos[0] <= 8'h55;
      repeat (300) if (param_update !== 1'b1) @(posedge pclk);
      chk(param_update, 1'b1);
      repeat (300) if (param_steps[15:0] !== 16'h5555) @(posedge pclk);
      chk(param_steps[15:0], 16'h5555);
      apb(1'b1, `UCTL_CTRL_OFS, 32'h2B);
      repeat (300) if (volume_gain !== 8'hC0) @(posedge pclk);
      chk(volume_gain, 8'hC0);
      second_memory_select_input <= 1'b1;
      repeat (40) if (telecoil_active !== 1'b1) @(posedge pclk);
      chk({telecoil_active, active_memory}, 3'h7);
      first_memory_select_input <= 1'b1;
      hold(8);
      first_memory_select_input <= 1'b0;
      hold(8); chk(active_memory, 2'h3);
      second_memory_select_input <= 1'b0;
      hold(3);
      second_memory_select_input <= 1'b1;
      hold(10); chk({telecoil_active, active_memory}, 3'h7);
      second_memory_select_input <= 1'b0;
      hold(6); chk({telecoil_active, active_memory}, 3'h7);
      repeat (40) if (telecoil_active !== 1'b0) @(posedge pclk);
      chk({telecoil_active, active_memory}, 3'h0);
      apb(1'b1, `UCTL_SVOL_OFS, 32'h33);
      apb(1'b1, `UCTL_CTRL_OFS, 32'h0);
      hold(4); chk(volume_gain, 8'h33);
      apb(1'b1, `UCTL_CTRL_OFS, 32'h196);
      vol_up_switch <= 1'b1;
      hold(8);
      vol_up_switch <= 1'b0;
      repeat (40) if (active_memory !== 2'h1) @(posedge pclk);
      chk(active_memory, 2'h1);
      vol_down_switch <= 1'b1;
      hold(8);
      vol_down_switch <= 1'b0;
      repeat (40) if (active_memory !== 2'h0) @(posedge pclk);
      chk(active_memory, 2'h0);
      apb(1'b1, `UCTL_CTRL_OFS, 32'h184);
      vol_up_switch <= 1'b1;
      hold(8);
      vol_up_switch <= 1'b0;
      repeat (40) if (volume_gain !== 8'h34) @(posedge pclk);
      chk(volume_gain, 8'h34);
      first_memory_select_input <= 1'b1;
      hold(8);
      first_memory_select_input <= 1'b0;
      repeat (40) if (active_memory !== 2'h1) @(posedge pclk);
      chk(active_memory, 2'h1);
      summarize;
   end
endmodule
bind uctl_top uctl_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .adc_sel, .adc_start, .param_update, .active_memory, .telecoil_active, .second_memory_select_input);
